// ---- logic/synth_cal_pkg.sv ----
// Constants for the synthesizer calibration register bank
package synth_cal_pkg;

	// ----------------------------------------------------------------
	// Register indices as printed; byte address is four times the index
	// ----------------------------------------------------------------
	localparam int          AXI_ADDR_W    = 20;
	localparam logic [15:0] IDX_VCO_CUR   = 16'hDF1D;
	localparam logic [15:0] IDX_COARSE    = 16'hDF1E;
	localparam logic [15:0] IDX_CTRL      = 16'hDF1F;
	localparam logic [17:0] WORD_VCO_CUR  = {2'h0, IDX_VCO_CUR};
	localparam logic [17:0] WORD_COARSE   = {2'h0, IDX_COARSE};
	localparam logic [17:0] WORD_CTRL     = {2'h0, IDX_CTRL};

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int         CORE_H_BIT     = 5;
	localparam logic       CORE_H_RST     = 1'b0;
	localparam logic [4:0] VCO_CUR_RST    = 5'h0A;
	localparam logic [5:0] COARSE_RST     = 6'h20;
	localparam logic [6:0] CTRL_RST       = 7'h0D;

	// ----------------------------------------------------------------
	// AXI response codes
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY      = 2'h0;
	localparam logic [1:0] RESP_SLVERR    = 2'h2;

endpackage : synth_cal_pkg

// ---- logic/synth_calibration_regs.sv ----
// Synthesizer calibration register bank behind an AXI4-Lite slave
// Function
// - One bit selects low or high oscillator core
// - Five-bit oscillator current result and override field
// - Six-bit coarse tuning capacitor array field
// - Seven-bit calibration control field, reset 0001101
// - Wake from deep sleep resets result registers
// - Written values are used like fresh results
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module synth_calibration_regs
	import synth_cal_pkg::*;
(
	input  wire logic                  aclk,                 // System clock, 100 MHz
	input  wire logic                  aresetn,              // Synchronous reset, active low
	input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,         // Write address
	input  wire logic                  s_axi_awvalid,        // Write address valid
	output logic                       s_axi_awready,        // Write address ready
	input  wire logic [31:0]           s_axi_wdata,          // Write data
	input  wire logic [3:0]            s_axi_wstrb,          // Write byte strobes
	input  wire logic                  s_axi_wvalid,         // Write data valid
	output logic                       s_axi_wready,         // Write data ready
	output logic [1:0]                 s_axi_bresp,          // Write response
	output logic                       s_axi_bvalid,         // Write response valid
	input  wire logic                  s_axi_bready,         // Write response ready
	input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,         // Read address
	input  wire logic                  s_axi_arvalid,        // Read address valid
	output logic                       s_axi_arready,        // Read address ready
	output logic [31:0]                s_axi_rdata,          // Read data
	output logic [1:0]                 s_axi_rresp,          // Read response
	output logic                       s_axi_rvalid,         // Read data valid
	input  wire logic                  s_axi_rready,         // Read data ready
	input  wire logic                  cal_capture,          // Calibration done pulse
	input  wire logic [4:0]            cal_vco_current_in,   // Current result from calibrator
	input  wire logic [5:0]            cal_coarse_cap_in,    // Capacitor result from calibrator
	input  wire logic                  wake_deep_sleep_a,    // Pulse: active after mode A
	input  wire logic                  wake_deep_sleep_b,    // Pulse: active after mode B
	output logic                       osc_core_high_select, // Oscillator core choice
	output logic [4:0]                 vco_current_cal,      // Current setting in use
	output logic [5:0]                 coarse_cap_cal,       // Capacitor setting in use
	output logic [6:0]                 cal_control           // Calibration control value
);

	// ----------------------------------------------------------------
	// Bus state
	// ----------------------------------------------------------------
	logic                  aw_held_reg, aw_held_next;
	logic [17:0]           aw_word_reg, aw_word_next;
	logic                  w_held_reg,  w_held_next;
	logic [6:0]            w_data_reg,  w_data_next;  // Bit 7 has no field behind it
	logic                  w_lane0_reg, w_lane0_next;
	logic                  bvalid_reg,  bvalid_next;
	logic [1:0]            bresp_reg,   bresp_next;
	logic                  rvalid_reg,  rvalid_next;
	logic [1:0]            rresp_reg,   rresp_next;
	logic [31:0]           rdata_reg,   rdata_next;

	// ----------------------------------------------------------------
	// Calibration state
	// ----------------------------------------------------------------
	logic                  core_h_reg,  core_h_next;
	logic [4:0]            vco_reg,     vco_next;
	logic [5:0]            coarse_reg,  coarse_next;
	logic [6:0]            ctrl_reg,    ctrl_next;

	logic                  do_write;
	logic                  wr_vco, wr_coarse, wr_ctrl;
	logic                  wake;
	logic [17:0]           ar_word;

	// Write fires once both halves are held; keeps the slave order-free
	assign do_write  = aw_held_reg && w_held_reg && !bvalid_reg;
	assign wr_vco    = do_write && w_lane0_reg && (aw_word_reg == WORD_VCO_CUR);
	assign wr_coarse = do_write && w_lane0_reg && (aw_word_reg == WORD_COARSE);
	assign wr_ctrl   = do_write && w_lane0_reg && (aw_word_reg == WORD_CTRL);
	assign wake      = wake_deep_sleep_a || wake_deep_sleep_b;
	assign ar_word   = s_axi_araddr[AXI_ADDR_W-1:2];

	// Handshake outputs straight from state
	assign s_axi_awready = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready  = !w_held_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rresp   = rresp_reg;
	assign s_axi_rdata   = rdata_reg;

	// Settings used by the synthesizer come from the registers directly
	assign osc_core_high_select = core_h_reg;
	assign vco_current_cal      = vco_reg;
	assign coarse_cap_cal       = coarse_reg;
	assign cal_control          = ctrl_reg;

	// ----------------------------------------------------------------
	// Bus next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		aw_held_next = aw_held_reg;
		aw_word_next = aw_word_reg;
		w_held_next  = w_held_reg;
		w_data_next  = w_data_reg;
		w_lane0_next = w_lane0_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		rvalid_next  = rvalid_reg;
		rresp_next   = rresp_reg;
		rdata_next   = rdata_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_next = 1'b1;
			aw_word_next = s_axi_awaddr[AXI_ADDR_W-1:2];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_next  = 1'b1;
			w_data_next  = s_axi_wdata[6:0];
			w_lane0_next = s_axi_wstrb[0];
		end
		if (do_write) begin
			aw_held_next = 1'b0;
			w_held_next  = 1'b0;
			bvalid_next  = 1'b1;
			case (aw_word_reg)
				WORD_VCO_CUR, WORD_COARSE, WORD_CTRL: begin
					bresp_next = RESP_OKAY;
				end
				default: begin
					bresp_next = RESP_SLVERR;
				end
			endcase
		end else if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		// Unused upper bits are packed as zero here
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_next = 1'b1;
			rresp_next  = RESP_OKAY;
			case (ar_word)
				WORD_VCO_CUR: begin
					rdata_next = {26'h0, core_h_reg, vco_reg};
				end
				WORD_COARSE: begin
					rdata_next = {26'h0, coarse_reg};
				end
				WORD_CTRL: begin
					rdata_next = {25'h0, ctrl_reg};
				end
				default: begin
					rdata_next = 32'h0;
					rresp_next = RESP_SLVERR;
				end
			endcase
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
	end

	// Bus registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			aw_word_reg <= 18'h0;
			w_held_reg  <= 1'b0;
			w_data_reg  <= 7'h00;
			w_lane0_reg <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
			rvalid_reg  <= 1'b0;
			rresp_reg   <= RESP_OKAY;
			rdata_reg   <= 32'h0;
		end else begin
			aw_held_reg <= aw_held_next;
			aw_word_reg <= aw_word_next;
			w_held_reg  <= w_held_next;
			w_data_reg  <= w_data_next;
			w_lane0_reg <= w_lane0_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			rvalid_reg  <= rvalid_next;
			rresp_reg   <= rresp_next;
			rdata_reg   <= rdata_next;
		end
	end

	// ----------------------------------------------------------------
	// Calibration register next-state logic
	// ----------------------------------------------------------------
	// Priority: wake, then calibrator capture, then software. A fresh
	// result must not be lost to a write landing in the same cycle.
	always_comb begin
		core_h_next = core_h_reg;
		vco_next    = vco_reg;
		coarse_next = coarse_reg;
		ctrl_next   = ctrl_reg;
		if (wr_vco) begin
			core_h_next = w_data_reg[CORE_H_BIT];
			vco_next    = w_data_reg[4:0];
		end
		if (wr_coarse) begin
			coarse_next = w_data_reg[5:0];
		end
		if (wr_ctrl) begin
			ctrl_next = w_data_reg[6:0];
		end
		if (cal_capture) begin
			vco_next    = cal_vco_current_in;
			coarse_next = cal_coarse_cap_in;
		end
		if (wake) begin
			core_h_next = CORE_H_RST;
			vco_next    = VCO_CUR_RST;
			coarse_next = COARSE_RST;
		end
	end

	// Calibration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_h_reg <= CORE_H_RST;
			vco_reg    <= VCO_CUR_RST;
			coarse_reg <= COARSE_RST;
			ctrl_reg   <= CTRL_RST;
		end else begin
			core_h_reg <= core_h_next;
			vco_reg    <= vco_next;
			coarse_reg <= coarse_next;
			ctrl_reg   <= ctrl_next;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_sw_only;
		!wake && !cal_capture;
	endsequence

	sequence s_vco_write;
		wr_vco ##0 s_sw_only;
	endsequence

	a_core_select_write: assert property (
		s_vco_write |=> osc_core_high_select == $past(w_data_reg[CORE_H_BIT])
	) else $error("core select did not take written bit");

	a_vco_write_used: assert property (
		s_vco_write |=> vco_current_cal == $past(w_data_reg[4:0])
	) else $error("current field did not take written value");

	a_coarse_write_used: assert property (
		wr_coarse && !wake && !cal_capture |=> coarse_cap_cal == $past(w_data_reg[5:0])
	) else $error("capacitor field did not take written value");

	a_ctrl_write: assert property (
		wr_ctrl |=> cal_control == $past(w_data_reg[6:0])
	) else $error("control field did not take written value");

	a_capture_load: assert property (
		cal_capture && !wake |=> vco_current_cal == $past(cal_vco_current_in)
			&& coarse_cap_cal == $past(cal_coarse_cap_in)
	) else $error("calibration result not captured");

	a_wake_reset: assert property (
		wake |=> vco_current_cal == VCO_CUR_RST && coarse_cap_cal == COARSE_RST
			&& osc_core_high_select == CORE_H_RST
	) else $error("result registers not reset on wake");

	a_wake_keeps_ctrl: assert property (
		wake && !wr_ctrl |=> $stable(cal_control)
	) else $error("control field disturbed by wake");

	a_upper_zero: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0
			&& (s_axi_rdata[7] == 1'b0)
	) else $error("unused read bits not zero");

	a_read_holds: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
	) else $error("read answer dropped before rready");

	a_write_answer: assert property (
		do_write |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready
	) else $error("write response missing");

	a_write_holds: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)
	) else $error("write answer dropped before bready");

endmodule : synth_calibration_regs

// ---- bench/synth_calibration_regs_bench.sv ----
// Self-checking bench for the synthesizer calibration register bank
`timescale 1ns/1ns
module synth_calibration_regs_bench
	import synth_cal_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals and design instance
	// ----------------------------------------------------------------
	localparam logic [19:0] A_CUR = {WORD_VCO_CUR, 2'h0};
	localparam logic [19:0] A_CAP = {WORD_COARSE, 2'h0};
	localparam logic [19:0] A_CTL = {WORD_CTRL, 2'h0};
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [19:0] s_axi_awaddr = 20'h0, s_axi_araddr = 20'h0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic        cal_capture = 1'b0, wake_deep_sleep_a = 1'b0, wake_deep_sleep_b = 1'b0;
	logic [4:0]  cal_vco_current_in = 5'h00;
	logic [5:0]  cal_coarse_cap_in = 6'h00;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic        osc_core_high_select;
	logic [4:0]  vco_current_cal;
	logic [5:0]  coarse_cap_cal;
	logic [6:0]  cal_control;
	int          mismatches = 0, checked = 0;
	logic [31:0] saved_cur, saved_cap;

	synth_calibration_regs dut (
		.aclk                 (aclk),
		.aresetn              (aresetn),
		.s_axi_awaddr         (s_axi_awaddr),
		.s_axi_awvalid        (s_axi_awvalid),
		.s_axi_awready        (s_axi_awready),
		.s_axi_wdata          (s_axi_wdata),
		.s_axi_wstrb          (s_axi_wstrb),
		.s_axi_wvalid         (s_axi_wvalid),
		.s_axi_wready         (s_axi_wready),
		.s_axi_bresp          (s_axi_bresp),
		.s_axi_bvalid         (s_axi_bvalid),
		.s_axi_bready         (s_axi_bready),
		.s_axi_araddr         (s_axi_araddr),
		.s_axi_arvalid        (s_axi_arvalid),
		.s_axi_arready        (s_axi_arready),
		.s_axi_rdata          (s_axi_rdata),
		.s_axi_rresp          (s_axi_rresp),
		.s_axi_rvalid         (s_axi_rvalid),
		.s_axi_rready         (s_axi_rready),
		.cal_capture          (cal_capture),
		.cal_vco_current_in   (cal_vco_current_in),
		.cal_coarse_cap_in    (cal_coarse_cap_in),
		.wake_deep_sleep_a    (wake_deep_sleep_a),
		.wake_deep_sleep_b    (wake_deep_sleep_b),
		.osc_core_high_select (osc_core_high_select),
		.vco_current_cal      (vco_current_cal),
		.coarse_cap_cal       (coarse_cap_cal),
		.cal_control          (cal_control)
	);

	// Free-running 100 MHz clock
	always #5 aclk = ~aclk;

	// ----------------------------------------------------------------
	// Compare, verdict and bus tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic stop_test();
		if (mismatches == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : stop_test

	// Readies are combinational from registers, so the negedge value is the edge value
	task automatic axi_write(input logic [19:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		logic taw, tw, tb, bv;
		logic [1:0] resp;
		s_axi_awaddr  <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata   <= d;
		s_axi_wstrb   <= s;
		s_axi_wvalid  <= 1'b1;
		tb = 1'b0;
		// bready comes only after bvalid is seen, so the answer must stand a cycle
		while (!tb) begin
			@(negedge aclk);
			taw  = s_axi_awvalid && s_axi_awready;
			tw   = s_axi_wvalid && s_axi_wready;
			tb   = s_axi_bvalid && s_axi_bready;
			bv   = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge aclk);
			if (taw) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (bv && !tb) s_axi_bready <= 1'b1;
		end
		s_axi_bready <= 1'b0;
		chk({30'h0, resp}, {30'h0, er});
	endtask : axi_write

	task automatic axi_read(input logic [19:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic tar, tr, rv;
		logic [31:0] d;
		logic [1:0] resp;
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		tr = 1'b0;
		// rready comes only after rvalid is seen, so the answer must stand a cycle
		while (!tr) begin
			@(negedge aclk);
			tar  = s_axi_arvalid && s_axi_arready;
			tr   = s_axi_rvalid && s_axi_rready;
			rv   = s_axi_rvalid;
			d    = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge aclk);
			if (tar) s_axi_arvalid <= 1'b0;
			if (rv && !tr) s_axi_rready <= 1'b1;
		end
		s_axi_rready <= 1'b0;
		chk(d, ed);
		chk({30'h0, resp}, {30'h0, er});
	endtask : axi_read

	// Outputs in use: core, current, capacitor, control
	task automatic chk_out(input logic [5:0] cur, input logic [5:0] cap, input logic [6:0] ctl);
		chk({26'h0, osc_core_high_select, vco_current_cal}, {26'h0, cur});
		chk({26'h0, coarse_cap_cal}, {26'h0, cap});
		chk({25'h0, cal_control}, {25'h0, ctl});
	endtask : chk_out

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk_out(6'h0A, 6'h20, 7'h0D);
		axi_read(A_CUR, 32'h0000000A, RESP_OKAY);
		axi_read(A_CAP, 32'h00000020, RESP_OKAY);
		axi_read(A_CTL, 32'h0000000D, RESP_OKAY);
		// Upper bits set on purpose; only the field bits may stick
		axi_write(A_CUR, 32'hFFFFFFE3, 4'hF, RESP_OKAY);
		axi_write(A_CAP, 32'hFFFFFF95, 4'hF, RESP_OKAY);
		axi_write(A_CTL, 32'hFFFFFFF2, 4'hF, RESP_OKAY);
		axi_read(A_CUR, 32'h00000023, RESP_OKAY);
		axi_read(A_CAP, 32'h00000015, RESP_OKAY);
		axi_read(A_CTL, 32'h00000072, RESP_OKAY);
		chk_out(6'h23, 6'h15, 7'h72);
		// Lane 0 strobe off and unmapped word leave everything alone
		axi_write(A_CTL, 32'h00000001, 4'hE, RESP_OKAY);
		axi_write(20'h00000, 32'h00000001, 4'hF, RESP_SLVERR);
		axi_read(20'h00000, 32'h00000000, RESP_SLVERR);
		chk_out(6'h23, 6'h15, 7'h72);
		// Wake from each deep sleep mode resets results, not control
		wake_deep_sleep_a <= 1'b1;
		@(posedge aclk);
		wake_deep_sleep_a <= 1'b0;
		@(posedge aclk);
		chk_out(6'h0A, 6'h20, 7'h72);
		axi_write(A_CUR, 32'h00000035, 4'h1, RESP_OKAY);
		axi_write(A_CAP, 32'h0000003F, 4'h1, RESP_OKAY);
		chk_out(6'h35, 6'h3F, 7'h72);
		wake_deep_sleep_b <= 1'b1;
		@(posedge aclk);
		wake_deep_sleep_b <= 1'b0;
		@(posedge aclk);
		axi_read(A_CUR, 32'h0000000A, RESP_OKAY);
		axi_read(A_CAP, 32'h00000020, RESP_OKAY);
		// Fresh calibration result, saved then restored by software
		cal_vco_current_in <= 5'h11;
		cal_coarse_cap_in  <= 6'h2A;
		cal_capture        <= 1'b1;
		@(posedge aclk);
		cal_capture <= 1'b0;
		@(posedge aclk);
		saved_cur = {26'h0, osc_core_high_select, vco_current_cal};
		saved_cap = {26'h0, coarse_cap_cal};
		chk(saved_cur, 32'h00000011);
		chk(saved_cap, 32'h0000002A);
		axi_write(A_CUR, 32'h00000004, 4'h1, RESP_OKAY);
		axi_write(A_CAP, 32'h00000001, 4'h1, RESP_OKAY);
		chk_out(6'h04, 6'h01, 7'h72);
		axi_write(A_CUR, saved_cur, 4'h1, RESP_OKAY);
		axi_write(A_CAP, saved_cap, 4'h1, RESP_OKAY);
		chk_out(6'h11, 6'h2A, 7'h72);
		// Wake and a capture in one cycle: the wake wins
		cal_capture       <= 1'b1;
		wake_deep_sleep_a <= 1'b1;
		@(posedge aclk);
		cal_capture       <= 1'b0;
		wake_deep_sleep_a <= 1'b0;
		@(posedge aclk);
		chk_out(6'h0A, 6'h20, 7'h72);
		stop_test();
	end

	// Watchdog: the sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge aclk);
		mismatches++;
		stop_test();
	end
endmodule : synth_calibration_regs_bench
